// ---- rtl/symcnt_irq_pkg.sv ----
// What this block does
// - A set flag is a pending request; when its mask bit is set it requests service and the flag clears when the service is acknowledged.
// - Writing one to a flag position of the pending register clears that flag and writing zero leaves it alone.
// - Bits 7:5 of both the pending and mask registers are reserved, read as zero here, and software writes them with zero.
// - The backoff tick flag at bit 4 is raised every 320 us, which is every 20 symbol periods.
// - The wrap flag at bit 3 is raised when the 32-bit symbol counter rolls from all ones to zero.
// - Bits 2, 1 and 0 are raised by compare matches of units three, two and one.
// - After reset every mask bit is zero so no interrupt is requested until software enables one.
// - An event with its mask bit clear still sets its flag but requests no interrupt.
// - Setting a mask bit while its flag is already set raises the request at once.
// - The mask bits sit at the flag positions: backoff 4, wrap 3, match units three to one at 2 to 0.
// - The backoff slot counter and its tick run only while the backoff counter enable bit is set.
// - A sync command clears the prescaler and the slot counter so the next tick follows a full 320 us.
package symcnt_irq_pkg;

   // ----------------------------------------
   // bus and register map
   // ----------------------------------------
   localparam int ADR_W = 10;
   localparam logic [7:0] IDX_PEND = 8'hdc;
   localparam logic [7:0] IDX_CTRL = 8'hdd;
   localparam logic [7:0] IDX_MASK = 8'hdf;

   // ----------------------------------------
   // field layout and reset values
   // ----------------------------------------
   localparam int NSRC = 5;
   localparam int BIT_MATCH1 = 0;
   localparam int BIT_MATCH2 = 1;
   localparam int BIT_MATCH3 = 2;
   localparam int BIT_WRAP = 3;
   localparam int BIT_BACKOFF = 4;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_SYNC_BIT = 7;
   localparam logic [NSRC-1:0] MASK_RST = 5'h0;
   localparam logic [NSRC-1:0] PEND_RST = 5'h0;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int SYMBOL_US = 16;
   localparam int BACKOFF_US = 320;
   localparam int SYMBOL_CYCLES = SYMBOL_US * CLK_MHZ;
   localparam int SLOT_SYMBOLS = BACKOFF_US / SYMBOL_US;

   // ----------------------------------------
   // bus slave states
   // ----------------------------------------
   typedef enum logic {WB_IDLE, WB_ACK} wb_state_t;

endpackage

// ---- rtl/backoff_ticker.sv ----
`timescale 1ns/1ns
module backoff_ticker #(
   parameter int SYM_CYC = 400,
   parameter int SLOT_SYMS = 20
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic enable_i,
   input wire logic sync_i,
   // event
   output logic tick_o
);

   // ----------------------------------------
   // prescaler and slot counter
   // ----------------------------------------
   logic [15:0] pre_ff, nxt_pre;
   logic [7:0] slot_ff, nxt_slot;
   logic pre_end, slot_end;

   assign pre_end = (pre_ff == 16'(SYM_CYC - 1));
   assign slot_end = (slot_ff == 8'(SLOT_SYMS - 1));
   assign tick_o = enable_i && !sync_i && pre_end && slot_end;

   always_comb begin
      nxt_pre = pre_ff;
      nxt_slot = slot_ff;
      if (sync_i) begin
         nxt_pre = 16'h0000;
         nxt_slot = 8'h00;
      end else if (enable_i) begin
         nxt_pre = pre_end ? 16'h0000 : pre_ff + 16'h0001;
         if (pre_end) begin
            nxt_slot = slot_end ? 8'h00 : slot_ff + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_ff <= 16'h0000;
         slot_ff <= 8'h00;
      end else begin
         pre_ff <= nxt_pre;
         slot_ff <= nxt_slot;
      end
   end

endmodule // backoff_ticker

// ---- rtl/symcnt_irq.sv ----
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module symcnt_irq
   import symcnt_irq_pkg::*;
#(
   parameter int SYM_CYC = SYMBOL_CYCLES,
   parameter int SLOT_SYMS = SLOT_SYMBOLS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic ack_o,
   output logic [31:0] dat_o,
   // events from counter and compare units
   input wire logic match1_i,
   input wire logic match2_i,
   input wire logic match3_i,
   input wire logic wrap_i,
   // processor interrupt side
   input wire logic [NSRC-1:0] vec_ack_i,
   output logic [NSRC-1:0] req_o,
   output logic irq_o
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [NSRC-1:0] flags_ff, nxt_flags;
   logic [NSRC-1:0] mask_ff, nxt_mask;
   logic bo_en_ff, nxt_bo_en;
   wb_state_t wb_ff, nxt_wb;
   logic [31:0] dat_ff, nxt_dat;
   logic [7:0] idx;
   logic commit;
   logic wr_pend, wr_mask, wr_ctrl;
   logic sync_pulse;
   logic backoff_tick;
   logic [NSRC-1:0] set_vec, clr_vec, w1c_vec;
   logic [31:0] rd_val;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign idx = adr_i[ADR_W-1:2];
   assign commit = cyc_i && stb_i && we_i && sel_i[0] && (wb_ff == WB_ACK);
   assign wr_pend = commit && (idx == IDX_PEND);
   assign wr_mask = commit && (idx == IDX_MASK);
   assign wr_ctrl = commit && (idx == IDX_CTRL);
   assign sync_pulse = wr_ctrl && dat_i[CTRL_SYNC_BIT];

   always_comb begin
      rd_val = RD_ZERO;
      unique case (idx)
         IDX_PEND: rd_val[NSRC-1:0] = flags_ff;
         IDX_MASK: rd_val[NSRC-1:0] = mask_ff;
         IDX_CTRL: rd_val[CTRL_EN_BIT] = bo_en_ff;
         default: rd_val = RD_ZERO;
      endcase
   end

   // ----------------------------------------
   // bus slave state
   // ----------------------------------------
   always_comb begin
      nxt_wb = wb_ff;
      nxt_dat = dat_ff;
      unique case (wb_ff)
         WB_IDLE: begin
            if (cyc_i && stb_i) begin
               nxt_wb = WB_ACK;
               nxt_dat = we_i ? RD_ZERO : rd_val;
            end
         end
         WB_ACK: begin
            nxt_wb = WB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ff <= WB_IDLE;
         dat_ff <= RD_ZERO;
      end else begin
         wb_ff <= nxt_wb;
         dat_ff <= nxt_dat;
      end
   end

   assign ack_o = (wb_ff == WB_ACK);
   assign dat_o = dat_ff;

   // ----------------------------------------
   // backoff slot timing
   // ----------------------------------------
   backoff_ticker #(
      .SYM_CYC(SYM_CYC),
      .SLOT_SYMS(SLOT_SYMS)
   ) u_ticker (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .enable_i(bo_en_ff),
      .sync_i(sync_pulse),
      .tick_o(backoff_tick)
   );

   // ----------------------------------------
   // flags, mask and control
   // ----------------------------------------
   always_comb begin
      set_vec = '0;
      set_vec[BIT_MATCH1] = match1_i;
      set_vec[BIT_MATCH2] = match2_i;
      set_vec[BIT_MATCH3] = match3_i;
      set_vec[BIT_WRAP] = wrap_i;
      set_vec[BIT_BACKOFF] = backoff_tick;
   end

   assign w1c_vec = wr_pend ? dat_i[NSRC-1:0] : '0;
   assign clr_vec = w1c_vec | vec_ack_i;

   always_comb begin
      nxt_flags = (flags_ff & ~clr_vec) | set_vec;
      nxt_mask = wr_mask ? dat_i[NSRC-1:0] : mask_ff;
      nxt_bo_en = wr_ctrl ? dat_i[CTRL_EN_BIT] : bo_en_ff;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_ff <= PEND_RST;
         mask_ff <= MASK_RST;
         bo_en_ff <= 1'b0;
      end else begin
         flags_ff <= nxt_flags;
         mask_ff <= nxt_mask;
         bo_en_ff <= nxt_bo_en;
      end
   end

   // ----------------------------------------
   // interrupt requests
   // ----------------------------------------
   assign req_o = flags_ff & mask_ff;
   assign irq_o = |req_o;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   int unsigned gap_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gap_ff <= 0;
      end else if (backoff_tick || sync_pulse) begin
         gap_ff <= 0;
      end else if (bo_en_ff) begin
         gap_ff <= gap_ff + 1;
      end
   end

   sequence enable_on_pending;
      wr_mask && ((dat_i[NSRC-1:0] & flags_ff & ~clr_vec) != '0);
   endsequence

   sequence quiet_event;
      (set_vec != '0) && (mask_ff == '0) && !wr_mask;
   endsequence

   mask_reset_a: assert property ($fell(rst_i) |-> mask_ff == '0)
      else $error("mask not zero after reset");

   w1c_clear_a: assert property (
      (wr_pend && dat_i[0] && !set_vec[0]) |=> !flags_ff[0])
      else $error("write one did not clear flag");

   flag_keep_a: assert property (
      1'b1 |=> (($past(flags_ff) & ~$past(clr_vec)) & ~flags_ff) == '0)
      else $error("flag lost without a clear");

   set_wins_a: assert property (
      (set_vec != '0) |=> ((~flags_ff) & $past(set_vec)) == '0)
      else $error("event not latched");

   pending_enable_a: assert property (enable_on_pending |=> irq_o)
      else $error("enable on pending flag gave no request");

   masked_event_a: assert property (
      quiet_event |=> !irq_o && (flags_ff != '0))
      else $error("masked event requested or was lost");

   vec_clear_a: assert property (
      ((vec_ack_i != '0) && (set_vec == '0)) |=> (req_o & $past(vec_ack_i)) == '0)
      else $error("vector acknowledge left request");

   backoff_period_a: assert property (
      backoff_tick |-> gap_ff == unsigned'(SYM_CYC * SLOT_SYMS - 1))
      else $error("backoff tick period wrong");

   backoff_stop_a: assert property (!bo_en_ff[*2] |-> !backoff_tick)
      else $error("backoff tick while disabled");

   sync_restart_a: assert property (sync_pulse |=> !backoff_tick[*2])
      else $error("tick right after sync");

   rsvd_zero_a: assert property (
      (ack_o && !we_i) |-> dat_o[31:NSRC] == '0)
      else $error("reserved bits read nonzero");

   wrap_flag_a: assert property (wrap_i |=> flags_ff[BIT_WRAP])
      else $error("wrap event not flagged");

endmodule // symcnt_irq

// ---- verif/irq_service_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// interrupt service side of the processor
// ----------------------------------------
module irq_service_model
   import symcnt_irq_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // service side
   input wire logic serve_i,
   input wire logic [NSRC-1:0] req_i,
   output logic [NSRC-1:0] vec_ack_o
);
   logic [NSRC-1:0] vec_ack_ff;
   logic [NSRC-1:0] nxt_vec_ack;
   always_comb begin
      nxt_vec_ack = '0;
      if (serve_i && vec_ack_ff == '0) begin
         nxt_vec_ack = req_i & (~req_i + 1'b1); // enters the lowest requesting source
      end
   end
   always_ff @(posedge clk_i) begin
      vec_ack_ff <= rst_i ? '0 : nxt_vec_ack;
   end
   assign vec_ack_o = vec_ack_ff;
endmodule // irq_service_model

// ---- verif/symcnt_irq_tb_top.sv ----
`timescale 1ns/1ns
module symcnt_irq_tb_top
   import symcnt_irq_pkg::*;
;
   logic clk, rst, cyc, stb, we, ack, serve;
   logic [ADR_W-1:0] adr;
   logic [3:0] sel, ev;
   logic [31:0] dat, rdat;
   logic [NSRC-1:0] vack, req;
   logic irq;
   int errors, check_count;
   symcnt_irq #(.SYM_CYC(4), .SLOT_SYMS(3)) u_symcnt_irq (.clk_i(clk), .rst_i(rst),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
      .ack_o(ack), .dat_o(rdat), .match1_i(ev[0]), .match2_i(ev[1]), .match3_i(ev[2]),
      .wrap_i(ev[3]), .vec_ack_i(vack), .req_o(req), .irq_o(irq));
   irq_service_model u_irq_service_model (.clk_i(clk), .rst_i(rst), .serve_i(serve),
      .req_i(req), .vec_ack_o(vack));
   // ----------------------------------------
   // common tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
         output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      dat <= {24'h00_0000, d};
      do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
      chk("ack", {31'h0, ack}, 32'h0000_0001);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask
   task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, idx, 8'h00, q);
      chk(nm, q, {24'h00_0000, e});
   endtask
   task automatic wrap_up();
      if (errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic masked_events();
      rd("mask", IDX_MASK, 8'h00);
      for (int i = 0; i < 4; i++) begin
         ev <= 4'h1 << i;
         @(posedge clk);
         ev <= 4'h0;
         rd("flags", IDX_PEND, 8'((2 << i) - 1));
      end
      chk("irq", {31'h0, irq}, 32'h0000_0000);
      wr(IDX_PEND, 8'h05);
      wr(IDX_PEND, 8'h00);
      rd("w1c", IDX_PEND, 8'h0a);
      rd("unmapped", 8'h00, 8'h00);
   endtask
   task automatic late_enable();
      wr(IDX_MASK, 8'h08);
      @(negedge clk);
      chk("req", {27'h0, req}, 32'h0000_0008);
      @(posedge clk);
      serve <= 1'b1;
      repeat (4) @(posedge clk);
      chk("irq", {31'h0, irq}, 32'h0000_0000);
      rd("serviced", IDX_PEND, 8'h02);
      serve <= 1'b0;
   endtask
   task automatic backoff();
      repeat (30) @(posedge clk);
      rd("idle", IDX_PEND, 8'h02);
      wr(IDX_CTRL, 8'h01);
      repeat (14) @(posedge clk);
      rd("tick", IDX_PEND, 8'h12);
      wr(IDX_CTRL, 8'h81);
      wr(IDX_PEND, 8'h10);
      rd("sync", IDX_PEND, 8'h02);
      wr(IDX_MASK, 8'h18);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("tick req", {27'h0, req}, 32'h0000_0010);
      @(posedge clk);
      wr(IDX_PEND, 8'h10);
      @(negedge clk);
      chk("tick cleared", {31'h0, irq}, 32'h0000_0000);
      @(posedge clk);
      rd("ctrl", IDX_CTRL, 8'h01);
   endtask
   // ----------------------------------------
   // clock, reset, sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      wrap_up();
   end
   initial begin
      {rst, cyc, stb, we, serve} = 5'h10;
      {adr, sel, ev, dat} = {10'h000, 4'hf, 4'h0, 32'h0000_0000};
      errors = 0;
      check_count = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      masked_events();
      late_enable();
      backoff();
      wrap_up();
   end
endmodule // symcnt_irq_tb_top
